//--- hdl/lcr_pkg.sv
// Constants for the laser-control configuration register bank.
// Assumes a byte-wide register space behind the two-wire serial slave.
package lcr_pkg;
  localparam logic [7:0] OFS_ANALOG_SETUP  = 8'h00;
  localparam logic [7:0] OFS_POWER_LOOP    = 8'h01;
  localparam logic [7:0] OFS_ADDR_TABLE    = 8'h02;

  localparam int BIT_SOFT_RESET  = 7;
  localparam int BIT_TEMP_ZONE   = 6;
  localparam int BIT_DIODE_FAULT = 5;
  localparam int BIT_OUT_ENABLE  = 4;
  localparam int BIT_MOD_REF     = 3;
  localparam int BIT_LOOP_SWAP   = 7;
  localparam int BIT_LOOP_GAIN   = 6;
  localparam int BIT_FB_REF      = 5;
  localparam int BIT_DRIVE_DIR   = 1;
  localparam int BIT_SHUTDOWN_OUTPUT_POL    = 0;

  // Bits of the first register kept in the non-volatile store
  localparam logic [7:0] ANALOG_NV_MASK    = 8'h5f;
  localparam logic [7:0] ANALOG_SETUP_INIT = 8'h00;
  localparam logic [7:0] POWER_LOOP_INIT   = 8'h00;
  localparam logic [7:0] ADDR_TABLE_INIT   = 8'ha0;
  localparam logic [2:0] SLAVE_ADDR_LOW    = 3'h3;

  localparam int ADC_TICK_DIV    = 125;
  localparam int ADC_CONV_TICKS  = 16;
endpackage

//--- hdl/lcr_nv_reg.sv
// One non-volatile configuration byte.
// Loaded with INIT_VAL only by power-on; warm and soft resets leave it alone.
`timescale 1ns/1ps
module lcr_nv_reg #(
  parameter int              WIDTH    = 8,
  parameter logic [WIDTH-1:0] INIT_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             por_n_in,
  input  wire logic             we_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  always_ff @(posedge clk_in) begin
    if (!por_n_in) begin
      q_out <= INIT_VAL;
    end else if (we_in) begin
      q_out <= d_in;
    end
  end
endmodule

//--- hdl/lcr_adc_seq.sv
// Conversion sequencer: runs back-to-back conversions, aborts on request,
// waits for resume before launching a fresh sequence.
`timescale 1ns/1ps
module lcr_adc_seq #(
  parameter int TICK_DIV   = lcr_pkg::ADC_TICK_DIV,
  parameter int CONV_TICKS = lcr_pkg::ADC_CONV_TICKS
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic abort_in,
  input  wire logic resume_in,
  output logic      start_out,
  output logic      discard_out,
  output logic      done_out,
  output logic      busy_out
);
  typedef enum logic [1:0] {SQ_LAUNCH, SQ_RUN, SQ_HOLD} lcr_seq_e;
  lcr_seq_e    state;
  logic [15:0] div_cnt;
  logic        tick;
  logic [15:0] conv_cnt;

  always_ff @(posedge clk_in) begin
    if (rst_in || state != SQ_RUN || div_cnt == 16'(TICK_DIV - 1)) begin
      div_cnt <= 16'h0000;
      tick    <= (state == SQ_RUN) && !rst_in;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    start_out   <= 1'b0;
    discard_out <= 1'b0;
    done_out    <= 1'b0;
    if (rst_in) begin
      state    <= SQ_LAUNCH;
      conv_cnt <= 16'h0000;
      busy_out <= 1'b0;
    end else begin
      case (state)
        SQ_LAUNCH: begin
          if (abort_in) begin
            state <= SQ_HOLD;
          end else begin
            start_out <= 1'b1;
            busy_out  <= 1'b1;
            conv_cnt  <= 16'h0000;
            state     <= SQ_RUN;
          end
        end
        SQ_RUN: begin
          if (abort_in) begin
            discard_out <= 1'b1;
            busy_out    <= 1'b0;
            state       <= SQ_HOLD;
          end else if (tick && conv_cnt == 16'(CONV_TICKS - 1)) begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state    <= SQ_LAUNCH;
          end else if (tick) begin
            conv_cnt <= conv_cnt + 16'h0001;
          end
        end
        SQ_HOLD: begin
          if (resume_in && !abort_in) begin
            state <= SQ_LAUNCH;
          end
        end
        default: state <= SQ_LAUNCH;
      endcase
    end
  end
endmodule

//--- hdl/lcr_config_regs.sv
// Configuration register bank with its two-wire serial slave.
// Assumes SCL/SDA already synchronous to clk_in; the open-drain SDA wire
// is resolved outside from sda_oe_out. Password check is done elsewhere.
`timescale 1ns/1ps
module lcr_config_regs #(
  parameter int TICK_DIV   = lcr_pkg::ADC_TICK_DIV,
  parameter int CONV_TICKS = lcr_pkg::ADC_CONV_TICKS
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       por_n_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       oem_password_valid_in,
  input  wire logic       diode_fault_in,
  input  wire logic       shutdown_request_in,
  input  wire logic [7:0] temperature_in,
  output logic            soft_reset_out,
  output logic            temp_zone_select_out,
  output logic            shutdown_output_out,
  output logic            shutdown_output_oe_out,
  output logic            analog_outputs_enable_out,
  output logic            modulation_reference_select_out,
  output logic [2:0]      monitor_voltage_select_out,
  output logic            loop_polarity_swap_out,
  output logic            loop_gain_select_out,
  output logic            feedback_reference_select_out,
  output logic [2:0]      feedback_resistor_select_out,
  output logic            drive_direction_select_out,
  output logic [3:0]      bus_address_nibble_out,
  output logic [7:0]      table_index_out,
  output logic            adc_start_out,
  output logic            adc_discard_out,
  output logic            adc_done_out
);
  typedef enum logic [2:0] {
    SB_IDLE, SB_ADDR, SB_ACK_ADDR, SB_RX, SB_ACK_RX, SB_TX, SB_ACK_TX
  } lcr_bus_e;

  lcr_bus_e   state;
  logic       scl_q;
  logic       sda_q;
  logic       scl_prev;
  logic       sda_prev;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [7:0] ptr;
  logic       first_byte;
  logic       rw_read;
  logic       wr_stb;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic       wr_ok;
  logic [7:0] rd_data;
  logic [7:0] analog_nv;
  logic [7:0] loop_nv;
  logic [7:0] addr_nv;
  logic       fault_flag;
  logic       soft_rst;
  logic       warm_rst;
  logic       abort_conv;
  logic       resume_pend;
  logic [3:0] table_offset;
  logic       seq_start;
  logic       seq_discard;
  logic       seq_done;
  logic [6:0] own_addr;

  assign scl_rise  = scl_q && !scl_prev;
  assign scl_fall  = !scl_q && scl_prev;
  assign start_det = scl_q && scl_prev && sda_prev && !sda_q;
  assign stop_det  = scl_q && scl_prev && !sda_prev && sda_q;
  assign own_addr  = {addr_nv[7:4], lcr_pkg::SLAVE_ADDR_LOW};
  assign warm_rst  = !reset_n_in || soft_rst;
  assign wr_ok     = wr_stb && oem_password_valid_in;

  always_ff @(posedge clk_in) begin
    scl_q    <= scl_in;
    sda_q    <= sda_in;
    scl_prev <= scl_q;
    sda_prev <= sda_q;
  end

  // Read view; nothing visible without the password
  always_comb begin
    rd_data = 8'h00;
    if (oem_password_valid_in) begin
      case (ptr)
        lcr_pkg::OFS_ANALOG_SETUP: begin
          rd_data = analog_nv & lcr_pkg::ANALOG_NV_MASK;
          rd_data[lcr_pkg::BIT_DIODE_FAULT] = fault_flag;
        end
        lcr_pkg::OFS_POWER_LOOP: rd_data = loop_nv;
        lcr_pkg::OFS_ADDR_TABLE: rd_data = addr_nv;
        default:                 rd_data = 8'h00;
      endcase
    end
  end

  // Serial slave engine
  always_ff @(posedge clk_in) begin
    wr_stb  <= 1'b0;
    sda_out <= 1'b0;
    if (!reset_n_in) begin
      state      <= SB_IDLE;
      sda_oe_out <= 1'b0;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      txsh       <= 8'h00;
      ptr        <= 8'h00;
      first_byte <= 1'b0;
      rw_read    <= 1'b0;
      wr_idx     <= 8'h00;
      wr_data    <= 8'h00;
    end else if (start_det) begin
      state      <= SB_ADDR;
      bit_cnt    <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_det) begin
      state      <= SB_IDLE;
      sda_oe_out <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        SB_ADDR, SB_RX: begin
          shreg   <= {shreg[6:0], sda_q};
          bit_cnt <= bit_cnt + 4'h1;
        end
        SB_TX: bit_cnt <= bit_cnt + 4'h1;
        SB_ACK_TX: begin
          if (sda_q) begin
            state <= SB_IDLE;
          end else begin
            ptr <= ptr + 8'h01;
          end
        end
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state)
        SB_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == own_addr) begin
              sda_oe_out <= 1'b1;
              rw_read    <= shreg[0];
              state      <= SB_ACK_ADDR;
            end else begin
              state <= SB_IDLE;
            end
          end
        end
        SB_ACK_ADDR: begin
          bit_cnt <= 4'h0;
          if (rw_read) begin
            sda_oe_out <= !rd_data[7];
            txsh       <= {rd_data[6:0], 1'b0};
            state      <= SB_TX;
          end else begin
            sda_oe_out <= 1'b0;
            first_byte <= 1'b1;
            state      <= SB_RX;
          end
        end
        SB_RX: begin
          if (bit_cnt == 4'h8) begin
            sda_oe_out <= 1'b1;
            first_byte <= 1'b0;
            state      <= SB_ACK_RX;
            if (first_byte) begin
              ptr <= shreg;
            end else begin
              wr_stb  <= 1'b1;
              wr_idx  <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h01;
            end
          end
        end
        SB_ACK_RX: begin
          sda_oe_out <= 1'b0;
          bit_cnt    <= 4'h0;
          state      <= SB_RX;
        end
        SB_TX: begin
          if (bit_cnt == 4'h8) begin
            sda_oe_out <= 1'b0;
            state      <= SB_ACK_TX;
          end else begin
            sda_oe_out <= !txsh[7];
            txsh       <= {txsh[6:0], 1'b0};
          end
        end
        SB_ACK_TX: begin
          bit_cnt    <= 4'h0;
          sda_oe_out <= !rd_data[7];
          txsh       <= {rd_data[6:0], 1'b0};
          state      <= SB_TX;
        end
        default: state <= SB_IDLE;
      endcase
    end
  end

  lcr_nv_reg #(.WIDTH(8), .INIT_VAL(lcr_pkg::ANALOG_SETUP_INIT)) u_analog_nv (
    .clk_in   (clk_in),
    .por_n_in (por_n_in),
    .we_in    (wr_ok && wr_idx == lcr_pkg::OFS_ANALOG_SETUP),
    .d_in     (wr_data & lcr_pkg::ANALOG_NV_MASK),
    .q_out    (analog_nv)
  );

  lcr_nv_reg #(.WIDTH(8), .INIT_VAL(lcr_pkg::POWER_LOOP_INIT)) u_loop_nv (
    .clk_in   (clk_in),
    .por_n_in (por_n_in),
    .we_in    (wr_ok && wr_idx == lcr_pkg::OFS_POWER_LOOP),
    .d_in     (wr_data),
    .q_out    (loop_nv)
  );

  lcr_nv_reg #(.WIDTH(8), .INIT_VAL(lcr_pkg::ADDR_TABLE_INIT)) u_addr_nv (
    .clk_in   (clk_in),
    .por_n_in (por_n_in),
    .we_in    (wr_ok && wr_idx == lcr_pkg::OFS_ADDR_TABLE),
    .d_in     (wr_data),
    .q_out    (addr_nv)
  );

  // Soft reset: one-cycle pulse on a one in the top bit
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      soft_rst       <= 1'b0;
      soft_reset_out <= 1'b0;
    end else begin
      soft_rst <= wr_ok && wr_idx == lcr_pkg::OFS_ANALOG_SETUP
                  && wr_data[lcr_pkg::BIT_SOFT_RESET];
      soft_reset_out <= soft_rst;
    end
  end

  // Volatile fault flag follows the diode monitor
  always_ff @(posedge clk_in) begin
    if (warm_rst) begin
      fault_flag <= 1'b0;
    end else begin
      fault_flag <= diode_fault_in;
    end
  end

  // Abort on a write to the analog setup or power-loop register, resume when the write transaction ends
  always_ff @(posedge clk_in) begin
    if (warm_rst) begin
      abort_conv  <= 1'b0;
      resume_pend <= 1'b0;
    end else begin
      abort_conv <= wr_ok && (wr_idx == lcr_pkg::OFS_ANALOG_SETUP
                    || wr_idx == lcr_pkg::OFS_POWER_LOOP);
      if (abort_conv) begin
        resume_pend <= 1'b1;
      end else if (start_det || stop_det) begin
        resume_pend <= 1'b0;
      end
    end
  end

  lcr_adc_seq #(.TICK_DIV(TICK_DIV), .CONV_TICKS(CONV_TICKS)) u_seq (
    .clk_in      (clk_in),
    .rst_in      (warm_rst),
    .abort_in    (abort_conv),
    .resume_in   (resume_pend && (start_det || stop_det)),
    .start_out   (seq_start),
    .discard_out (seq_discard),
    .done_out    (seq_done),
    .busy_out    ()
  );

  // Table offset sampled only at warm reset
  always_ff @(posedge clk_in) begin
    if (warm_rst) begin
      table_offset <= addr_nv[3:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      table_index_out <= 8'h00;
    end else begin
      table_index_out <= temperature_in + {4'h0, table_offset};
    end
  end

  // Configuration outputs, registered from the stores; conversion strobes, registered from the sequencer
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      temp_zone_select_out            <= 1'b0;
      analog_outputs_enable_out       <= 1'b0;
      shutdown_output_oe_out          <= 1'b0;
      shutdown_output_out             <= 1'b0;
      modulation_reference_select_out <= 1'b0;
      monitor_voltage_select_out      <= 3'h0;
      loop_polarity_swap_out          <= 1'b0;
      loop_gain_select_out            <= 1'b0;
      feedback_reference_select_out   <= 1'b0;
      feedback_resistor_select_out    <= 3'h0;
      drive_direction_select_out      <= 1'b0;
      bus_address_nibble_out          <= 4'h0;
      adc_start_out                   <= 1'b0;
      adc_discard_out                 <= 1'b0;
      adc_done_out                    <= 1'b0;
    end else begin
      temp_zone_select_out            <= analog_nv[lcr_pkg::BIT_TEMP_ZONE];
      analog_outputs_enable_out       <= analog_nv[lcr_pkg::BIT_OUT_ENABLE];
      shutdown_output_oe_out          <= analog_nv[lcr_pkg::BIT_OUT_ENABLE];
      // Active level per polarity bit
      shutdown_output_out <= shutdown_request_in == loop_nv[lcr_pkg::BIT_SHUTDOWN_OUTPUT_POL];
      modulation_reference_select_out <= analog_nv[lcr_pkg::BIT_MOD_REF];
      monitor_voltage_select_out      <= analog_nv[2:0];
      loop_polarity_swap_out          <= loop_nv[lcr_pkg::BIT_LOOP_SWAP];
      loop_gain_select_out            <= loop_nv[lcr_pkg::BIT_LOOP_GAIN];
      feedback_reference_select_out   <= loop_nv[lcr_pkg::BIT_FB_REF];
      // Zero opens the resistor; each step doubles it
      feedback_resistor_select_out    <= loop_nv[4:2];
      drive_direction_select_out      <= loop_nv[lcr_pkg::BIT_DRIVE_DIR];
      bus_address_nibble_out          <= addr_nv[7:4];
      adc_start_out                   <= seq_start;
      adc_discard_out                 <= seq_discard;
      adc_done_out                    <= seq_done;
    end
  end
endmodule

//--- bench/lcr_host_model.sv
// Two-wire serial host that drives the register bank's bus pins.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module lcr_host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Start or repeated start
  task automatic start_cond;
    sda_low_out = 1'b0;
    cyc(6);
    scl_out = 1'b1;
    cyc(6);
    sda_low_out = 1'b1;
    cyc(6);
    scl_out = 1'b0;
    cyc(2);
  endtask
  task automatic stop_cond;
    sda_low_out = 1'b1;
    cyc(6);
    scl_out = 1'b1;
    cyc(6);
    sda_low_out = 1'b0;
    cyc(10);
  endtask
  // Data held through the whole high phase
  task automatic bit_io(input logic b, output logic s);
    sda_low_out = ~b;
    cyc(6);
    scl_out = 1'b1;
    cyc(6);
    s = sda_in;
    scl_out = 1'b0;
    cyc(2);
  endtask
  // MSB first, ninth bit sent as given and its level returned
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
                      output logic lvl);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(nine, lvl);
  endtask
endmodule

//--- bench/lcr_config_regs_props.sv
// Concurrent checks on the configuration bank's top-level ports.
// Assumes one clock domain and a conversion longer than eight cycles.
`timescale 1ns/1ps
module lcr_config_regs_props #(
  parameter int TICK_DIV   = 2,
  parameter int CONV_TICKS = 2
) (
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  input wire logic       scl_in,
  input wire logic       oem_password_valid_in,
  input wire logic       shutdown_request_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       soft_reset_out,
  input wire logic       temp_zone_select_out,
  input wire logic       shutdown_output_out,
  input wire logic       shutdown_output_oe_out,
  input wire logic       analog_outputs_enable_out,
  input wire logic [2:0] monitor_voltage_select_out,
  input wire logic [2:0] feedback_resistor_select_out,
  input wire logic [3:0] bus_address_nibble_out,
  input wire logic       adc_start_out,
  input wire logic       adc_discard_out,
  input wire logic       adc_done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  oe_match_a: assert property (analog_outputs_enable_out == shutdown_output_oe_out)
    else $error("output enables disagree");
  soft_pulse_a: assert property (soft_reset_out |=> (!soft_reset_out)[*8])
    else $error("soft reset pulse too long or repeated");
  abort_hold_a: assert property (adc_discard_out |=> (!adc_done_out)[*8] ##[1:200] adc_start_out)
    else $error("aborted conversion completed or never restarted");
  pulse_width_a: assert property ((adc_start_out |=> !adc_start_out) and
                                  (adc_done_out |=> !adc_done_out))
    else $error("conversion pulse longer than one cycle");
  cfg_guard_a: assert property ($past(reset_n_in) && $past(reset_n_in, 2) && $changed({temp_zone_select_out,
      monitor_voltage_select_out, feedback_resistor_select_out, bus_address_nibble_out})
      |-> $past(oem_password_valid_in))
    else $error("configuration changed without password");
  sda_hold_a: assert property ($rose(scl_in) |=> $stable(sda_oe_out)[*4])
    else $error("data line moved while clock high");
  drive_low_a: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
  shutdown_output_follow_a: assert property ($changed(shutdown_request_in) && $past(reset_n_in)
      |=> $changed(shutdown_output_out))
    else $error("shutdown output ignored request");

  cover property (soft_reset_out);
  cover property (adc_discard_out);
  cover property ($changed(bus_address_nibble_out));
endmodule

bind lcr_config_regs lcr_config_regs_props #(.TICK_DIV(TICK_DIV), .CONV_TICKS(CONV_TICKS)) u_props (
  .clk_in, .reset_n_in, .scl_in, .oem_password_valid_in, .shutdown_request_in, .sda_out,
  .sda_oe_out, .soft_reset_out, .temp_zone_select_out, .shutdown_output_out,
  .shutdown_output_oe_out, .analog_outputs_enable_out, .monitor_voltage_select_out,
  .feedback_resistor_select_out, .bus_address_nibble_out, .adc_start_out, .adc_discard_out,
  .adc_done_out);

//--- bench/lcr_config_regs_tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the serial host model and the bound port checker.
`timescale 1ns/1ps
module lcr_config_regs_tb_top;
  logic       clk_in, reset_n_in, por_n_in, scl_in, sda_out, sda_oe_out, host_low;
  logic       oem_password_valid_in, diode_fault_in, shutdown_request_in, soft_reset_out;
  logic       temp_zone_select_out, shutdown_output_out, shutdown_output_oe_out;
  logic       analog_outputs_enable_out, modulation_reference_select_out, adc_start_out;
  logic       loop_polarity_swap_out, loop_gain_select_out, feedback_reference_select_out;
  logic       drive_direction_select_out, adc_discard_out, adc_done_out;
  logic [2:0] monitor_voltage_select_out, feedback_resistor_select_out;
  logic [3:0] bus_address_nibble_out;
  logic [7:0] temperature_in, table_index_out;
  logic [6:0] dev;
  wire  logic sda_in = ~(host_low | sda_oe_out);
  wire  logic [7:0] an_view = {1'b0, temp_zone_select_out, 1'b0, analog_outputs_enable_out,
                               modulation_reference_select_out, monitor_voltage_select_out};
  wire  logic [7:0] loop_view = {loop_polarity_swap_out, loop_gain_select_out,
    feedback_reference_select_out, feedback_resistor_select_out, drive_direction_select_out, 1'b0};
  int         fail_count, num_checks, n_soft, n_disc;
  realtime    t_disc, t_start;

  lcr_config_regs #(.TICK_DIV(20), .CONV_TICKS(4)) DUT (
    .clk_in, .reset_n_in, .por_n_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .oem_password_valid_in, .diode_fault_in, .shutdown_request_in, .temperature_in,
    .soft_reset_out, .temp_zone_select_out, .shutdown_output_out, .shutdown_output_oe_out,
    .analog_outputs_enable_out, .modulation_reference_select_out, .monitor_voltage_select_out,
    .loop_polarity_swap_out, .loop_gain_select_out, .feedback_reference_select_out,
    .feedback_resistor_select_out, .drive_direction_select_out, .bus_address_nibble_out,
    .table_index_out, .adc_start_out, .adc_discard_out, .adc_done_out);
  lcr_host_model host (.clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(host_low));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (soft_reset_out === 1'b1) n_soft++;
    if (adc_discard_out === 1'b1) begin
      n_disc++;
      t_disc = $realtime;
    end
    if (adc_start_out === 1'b1) t_start = $realtime;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic a0, a1;
    host.start_cond();
    host.xfer({dev, 1'b0}, 1'b1, r, a0);
    host.xfer(ptr, 1'b1, r, a1);
    host.xfer(d, 1'b1, r, a1);
    host.stop_cond();
    chk({7'b0, ~a0}, {7'b0, exp_ack});
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    host.start_cond();
    host.xfer({dev, 1'b0}, 1'b1, r, a);
    host.xfer(ptr, 1'b1, r, a);
    host.start_cond();
    host.xfer({dev, 1'b1}, 1'b1, r, a);
    host.xfer(8'hff, 1'b1, d, a);
    host.stop_cond();
  endtask

  task automatic t_defaults;
    logic [7:0] r;
    chk({4'h0, bus_address_nibble_out}, 8'h0a);
    chk(table_index_out, temperature_in);
    rd(lcr_pkg::OFS_ADDR_TABLE, r);
    chk(r, lcr_pkg::ADDR_TABLE_INIT);
    rd(lcr_pkg::OFS_POWER_LOOP, r);
    chk(r, lcr_pkg::POWER_LOOP_INIT);
  endtask
  task automatic t_analog;
    logic [7:0] v, r;
    logic [2:0] c;
    int d, s;
    s = n_soft;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      v = {1'b0, c[0], 1'b0, c[1], c[2], c};
      d = n_disc;
      wr(lcr_pkg::OFS_ANALOG_SETUP, v, 1'b1);
      chk(an_view, v);
      chk({7'b0, shutdown_output_oe_out}, {7'b0, v[4]});
      chk(8'(n_disc - d), 8'h01);
      chk({7'b0, t_start > t_disc}, 8'h01);
      rd(lcr_pkg::OFS_ANALOG_SETUP, r);
      chk(r, v);
    end
    chk(8'(n_soft - s), 8'h00);
    wr(lcr_pkg::OFS_ANALOG_SETUP, 8'hd0, 1'b1);
    chk(8'(n_soft - s), 8'h01);
    diode_fault_in = 1'b1;
    rd(lcr_pkg::OFS_ANALOG_SETUP, r);
    chk(r, 8'h70);
    diode_fault_in = 1'b0;
  endtask
  task automatic t_loop;
    logic [7:0] v, r;
    logic [2:0] c;
    int d;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      v = {c[0], ~c[0], c[1], c, c[2], c[1]};
      d = n_disc;
      wr(lcr_pkg::OFS_POWER_LOOP, v, 1'b1);
      chk(loop_view, {v[7:1], 1'b0});
      chk(8'(n_disc - d), 8'h01);
      for (int q = 0; q < 2; q++) begin
        shutdown_request_in = q[0];
        host.cyc(3);
        chk({7'b0, shutdown_output_out}, {7'b0, q[0] == v[0]});
      end
      rd(lcr_pkg::OFS_POWER_LOOP, r);
      chk(r, v);
    end
  endtask
  task automatic t_password;
    logic [7:0] a, l, r;
    a = an_view;
    l = loop_view;
    oem_password_valid_in = 1'b0;
    wr(lcr_pkg::OFS_ANALOG_SETUP, ~a, 1'b1);
    wr(lcr_pkg::OFS_POWER_LOOP, ~l, 1'b1);
    chk(an_view, a);
    chk(loop_view, l);
    rd(lcr_pkg::OFS_ANALOG_SETUP, r);
    chk(r, 8'h00);
    oem_password_valid_in = 1'b1;
  endtask
  task automatic t_address;
    logic [7:0] a, l, r;
    a = an_view;
    l = loop_view;
    wr(lcr_pkg::OFS_ADDR_TABLE, 8'h3c, 1'b1);
    chk({4'h0, bus_address_nibble_out}, 8'h03);
    wr(lcr_pkg::OFS_ADDR_TABLE, 8'h3c, 1'b0);
    dev = {4'h3, lcr_pkg::SLAVE_ADDR_LOW};
    rd(lcr_pkg::OFS_ADDR_TABLE, r);
    chk(r, 8'h3c);
    chk(table_index_out, temperature_in);
    reset_n_in = 1'b0;
    host.cyc(3);
    reset_n_in = 1'b1;
    host.cyc(3);
    chk(table_index_out, temperature_in + 8'h0c);
    chk(an_view, a);
    chk(loop_view, l);
    rd(lcr_pkg::OFS_ADDR_TABLE, r);
    chk(r, 8'h3c);
    // Index wraps modulo 256
    temperature_in = 8'hf8;
    host.cyc(3);
    chk(table_index_out, 8'h04);
    // Power-on reset reloads the stores and the default slave address
    reset_n_in = 1'b0;
    por_n_in = 1'b0;
    host.cyc(3);
    reset_n_in = 1'b1;
    por_n_in = 1'b1;
    host.cyc(3);
    chk({4'h0, bus_address_nibble_out}, 8'h0a);
    chk(table_index_out, 8'hf8);
    dev = {4'ha, lcr_pkg::SLAVE_ADDR_LOW};
    rd(lcr_pkg::OFS_ADDR_TABLE, r);
    chk(r, lcr_pkg::ADDR_TABLE_INIT);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #600000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    reset_n_in = 1'b0;
    por_n_in = 1'b0;
    oem_password_valid_in = 1'b1;
    diode_fault_in = 1'b0;
    shutdown_request_in = 1'b0;
    temperature_in = 8'h25;
    dev = {4'ha, lcr_pkg::SLAVE_ADDR_LOW};
    host.cyc(3);
    reset_n_in = 1'b1;
    por_n_in = 1'b1;
    host.cyc(4);
    t_defaults();
    t_analog();
    t_loop();
    t_password();
    t_address();
    report_and_stop();
  end
endmodule
